// *** design/pin_input_sync.sv ***
// Purpose: two-flop synchroniser for a vector of pin inputs
// Assumes: inputs asynchronous to ref_clk
// Notes:   first stage read only by the second
module pin_input_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  initial begin
    if (WIDTH < 1) $error("pin_input_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// *** design/port3_cfg.svh ***
// Purpose: constants for the port 3 pin function block
// Assumes: APB byte addresses, one register per aligned word
// Notes:   offsets are local to this block
`ifndef PORT3_CFG_SVH
`define PORT3_CFG_SVH

// ==========================================================
// Register offsets
`define OFS_PORT_DATA      12'h000
`define OFS_PORT_DIR       12'h004
`define OFS_PULLUP         12'h008
`define OFS_EXT_CLK_MODE   12'h00c
`define OFS_PORT_FUNC_MODE 12'h010
`define OFS_VARIANT        12'h014

// ==========================================================
// Reset values
`define RST_PORT_FUNC_MODE 8'h04
`define RST_EXT_CLK_MODE   8'h58
`define RST_ZERO8          8'h00

// ==========================================================
// Field positions
`define FM_EVT_LOW   7
`define FM_EVT_HIGH  6
`define FM_WDT_CLK   5
`define FM_NOISE     4
`define FM_EXTERNAL_INTERRUPT_ZERO      3
`define FM_RESET_OUT 2
`define FM_UP_DOWN   1
`define FM_PWM       0
`define EC_EXT_CLK   7
`define EC_FIXED_ONE 8'h58
`define EC_RW_MASK   8'ha7
`define FM_RSTO_MASK 8'h04

// ==========================================================
// Watchdog clock dividers
`define WDT_SYS_DIV  8192
`define WDT_SUB_DIV  32

`endif

// *** design/port3_pin_function_select.sv ***
// Purpose: port 3 pin function selection with APB register access
// Assumes: 10 MHz ref_clk, pins and subclock enter asynchronously
// Notes:   pin level outputs and enables come from flip-flops
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`include "port3_cfg.svh"

// What this block does
// - Port function mode register is 8 bits, read/write, reset to 0x04.
// - Bit 7 routes pin 7 to low-side event counter input; 0 means I/O.
// - Bit 6 routes pin 6 to high-side event counter input; 0 means I/O.
// - Bit 5 picks watchdog clock: system/8192 at 0, subclock/32 at 1.
// - Bit 4 enables the capture input noise canceller; 0 bypasses it.
// - Bit 3 makes neighbouring port bit 3 interrupt zero input.
// - Bit 2 drives pin 2 as active-low reset output; reset default set.
// - Variants without reset output treat bit 2 as reserved, writes ignored.
// - Bit 1 makes pin 1 the up/down control input; 0 means I/O.
// - Bit 0 drives pin 0 from the PWM output; 0 means I/O.
// - External clock mode register is 8 bits, reset to 0x58.
// - Its bit 7 makes pin 1 external clock input, overriding other uses.
// - Its bits 6, 4 and 3 read as 1; writes have no effect.
// - Its bits 5 and 2 to 0 store and return written values.
// - Pin 7 obeys direction in I/O mode, is event input otherwise.
// - Pin 6 obeys direction in I/O mode, is event input otherwise.
// - Direction 1 means output; direction and data act only in I/O mode.
// - Port read gives stored data for outputs, pin level for inputs.
module port3_pin_function_select
  import port3_pkg::*;
#(
  parameter bit HAS_RESET_OUT = 1'b1,
  parameter int WDT_SYS_DIV   = `WDT_SYS_DIV,
  parameter int WDT_SUB_DIV   = `WDT_SUB_DIV
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Port 3 pins
  input  wire logic [7:0]  port_pin_in,
  output logic      [7:0]  port_pin_out,
  output logic      [7:0]  port_pin_oe,
  output logic      [7:0]  port_pullup_en,
  // Neighbouring port bit 3
  input  wire logic        neighbour_bit3_in,
  output logic             neighbour_bit3_data,
  output logic             external_interrupt_zero,
  // Peripheral side
  input  wire logic        pwm_in,
  input  wire logic        chip_reset_active,
  input  wire logic        subclock_in,
  output logic             event_count_low_input,
  output logic             event_count_high_input,
  output logic             up_down_control_input,
  output logic             external_clock_input,
  output logic             external_clock_enable,
  output logic             timer_capture_input,
  output logic             capture_noise_filter_enable,
  output logic             watchdog_clock_select,
  output logic             watchdog_tick
);

  // Counter widths follow the dividers so a shortened divider stays exact
  localparam int SYS_W = (WDT_SYS_DIV > 1) ? $clog2(WDT_SYS_DIV) : 1;
  localparam int SUB_W = (WDT_SUB_DIV > 1) ? $clog2(WDT_SUB_DIV) : 1;

  initial begin
    if (WDT_SYS_DIV < 2)
      $error("port3_pin_function_select: WDT_SYS_DIV must be at least 2");
    if (WDT_SUB_DIV < 2)
      $error("port3_pin_function_select: WDT_SUB_DIV must be at least 2");
  end

  // ==========================================================
  // Synchronised pins
  localparam int SYNC_W = 10;
  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_val;
  logic [7:0]        pin_level;
  logic              neighbour_level;
  logic              subclock_level;

  assign sync_raw = {subclock_in, neighbour_bit3_in, port_pin_in};

  pin_input_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .async_in (sync_raw),
    .sync_out (sync_val)
  );

  assign pin_level       = sync_val[7:0];
  assign neighbour_level = sync_val[8];
  assign subclock_level  = sync_val[9];

  // ==========================================================
  // APB decode
  logic        wr_en;
  logic        rd_en;
  logic        addr_hit;
  logic [31:0] rd_word;

  function automatic logic is_mapped(input logic [11:0] a);
    return a == `OFS_PORT_DATA || a == `OFS_PORT_DIR || a == `OFS_PULLUP ||
           a == `OFS_EXT_CLK_MODE || a == `OFS_PORT_FUNC_MODE || a == `OFS_VARIANT;
  endfunction

  // One register write strobe per offset
  function automatic logic wr_hit(input logic        strobe,
                                  input logic [11:0] a,
                                  input logic [11:0] ofs);
    return strobe && a == ofs;
  endfunction

  // Zero wait states: every access phase ends at its first edge
  assign pready   = 1'b1;
  assign addr_hit = is_mapped(paddr);
  // Byte lane 0 carries every register; a write without it is dropped
  assign wr_en    = psel && penable && pwrite && addr_hit && pstrb[0];
  // Read data is fetched in the setup cycle so it stands through access
  assign rd_en    = psel && !penable && !pwrite;

  // ==========================================================
  // Registers
  byte_t port_data_q;
  byte_t port_dir_q;
  byte_t pullup_q;
  byte_t func_mode_q;
  byte_t ext_clk_q;
  byte_t func_rw_mask;

  // Byte lanes above the first are ignored: all registers are 8 bits
  assign func_rw_mask = HAS_RESET_OUT ? 8'hff : ~`FM_RSTO_MASK;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_data_q <= `RST_ZERO8;
    end else if (wr_hit(wr_en, paddr, `OFS_PORT_DATA)) begin
      port_data_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_dir_q <= `RST_ZERO8;
    end else if (wr_hit(wr_en, paddr, `OFS_PORT_DIR)) begin
      port_dir_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pullup_q <= `RST_ZERO8;
    end else if (wr_hit(wr_en, paddr, `OFS_PULLUP)) begin
      pullup_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      // Variant without reset output resets bit 2 low and keeps it there
      func_mode_q <= HAS_RESET_OUT ? `RST_PORT_FUNC_MODE
                                   : (`RST_PORT_FUNC_MODE & ~`FM_RSTO_MASK);
    end else if (wr_hit(wr_en, paddr, `OFS_PORT_FUNC_MODE)) begin
      func_mode_q <= (pwdata[7:0] & func_rw_mask) | (func_mode_q & ~func_rw_mask);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_clk_q <= `RST_EXT_CLK_MODE;
    end else if (wr_hit(wr_en, paddr, `OFS_EXT_CLK_MODE)) begin
      ext_clk_q <= (pwdata[7:0] & `EC_RW_MASK) | `EC_FIXED_ONE;
    end
  end

  // ==========================================================
  // Pin function decode
  logic  sel_evt_low;
  logic  sel_evt_high;
  logic  sel_rst_out;
  logic  sel_up_down;
  logic  sel_ext_clk;
  logic  sel_pwm;
  byte_t periph_mode;
  byte_t gpio_oe;
  byte_t port_read;

  assign sel_evt_low  = func_mode_q[`FM_EVT_LOW];
  assign sel_evt_high = func_mode_q[`FM_EVT_HIGH];
  assign sel_rst_out  = HAS_RESET_OUT && func_mode_q[`FM_RESET_OUT];
  assign sel_ext_clk  = ext_clk_q[`EC_EXT_CLK];
  assign sel_up_down  = func_mode_q[`FM_UP_DOWN] && !sel_ext_clk;
  assign sel_pwm      = func_mode_q[`FM_PWM];

  // Pins 5..3 carry no function here; they stay general I/O
  assign periph_mode = {sel_evt_low, sel_evt_high, 3'b000, sel_rst_out,
                        sel_up_down || sel_ext_clk, sel_pwm};

  assign gpio_oe = port_dir_q & ~periph_mode;

  // Input pins show the live level, output pins the stored data
  assign port_read = (port_dir_q & port_data_q) | (~port_dir_q & pin_level);

  // ==========================================================
  // Pin drivers, next values
  byte_t pin_oe_d;
  byte_t pin_out_d;
  byte_t pullup_en_d;

  // A special function overrides the GPIO setting of its own pin only
  always_comb begin
    pin_oe_d  = gpio_oe;
    pin_out_d = port_data_q;
    // Reset output: low while chip reset is active
    if (sel_rst_out) begin
      pin_oe_d[`FM_RESET_OUT]  = 1'b1;
      pin_out_d[`FM_RESET_OUT] = !chip_reset_active;
    end
    if (sel_pwm) begin
      pin_oe_d[`FM_PWM]  = 1'b1;
      pin_out_d[`FM_PWM] = pwm_in;
    end
  end

  // Pull-ups only on GPIO inputs; a driven pin would fight them
  assign pullup_en_d = pullup_q & ~port_dir_q & ~periph_mode;

  // ==========================================================
  // Pin drivers, registered
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_pin_out   <= '0;
      port_pin_oe    <= '0;
      port_pullup_en <= '0;
    end else begin
      port_pin_out   <= pin_out_d;
      port_pin_oe    <= pin_oe_d;
      port_pullup_en <= pullup_en_d;
    end
  end

  // ==========================================================
  // Peripheral inputs, gated by selection
  // Deselected inputs read 0 so an idle peripheral sees no edges
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      event_count_low_input       <= 1'b0;
      event_count_high_input      <= 1'b0;
      up_down_control_input       <= 1'b0;
      external_clock_input        <= 1'b0;
      external_clock_enable       <= 1'b0;
      timer_capture_input         <= 1'b0;
      capture_noise_filter_enable <= 1'b0;
      watchdog_clock_select       <= 1'b0;
      external_interrupt_zero     <= 1'b0;
      neighbour_bit3_data         <= 1'b0;
    end else begin
      event_count_low_input  <= sel_evt_low  && pin_level[`FM_EVT_LOW];
      event_count_high_input <= sel_evt_high && pin_level[`FM_EVT_HIGH];
      up_down_control_input  <= sel_up_down  && pin_level[`FM_UP_DOWN];
      external_clock_input   <= sel_ext_clk  && pin_level[`FM_UP_DOWN];
      external_clock_enable  <= sel_ext_clk;
      // Capture pin sits on another port; the filter bit is passed on
      timer_capture_input         <= 1'b0;
      capture_noise_filter_enable <= func_mode_q[`FM_NOISE];
      watchdog_clock_select       <= func_mode_q[`FM_WDT_CLK];
      external_interrupt_zero     <= func_mode_q[`FM_EXTERNAL_INTERRUPT_ZERO] && neighbour_level;
      neighbour_bit3_data         <= !func_mode_q[`FM_EXTERNAL_INTERRUPT_ZERO] && neighbour_level;
    end
  end

  // ==========================================================
  // Watchdog source clock divider
  logic [SYS_W-1:0] sys_div_q;
  logic [SUB_W-1:0] sub_div_q;
  logic             sub_prev_q;
  logic             sub_rise;
  wdt_src_e         wdt_src;

  assign wdt_src  = func_mode_q[`FM_WDT_CLK] ? WDT_SRC_SUB : WDT_SRC_SYS;
  // Subclock edges come through the synchroniser; it must stay well below ref_clk
  assign sub_rise = subclock_level && !sub_prev_q;

  // Both dividers run all the time, so a source switch needs no restart

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sys_div_q     <= '0;
      sub_div_q     <= '0;
      sub_prev_q    <= 1'b0;
      watchdog_tick <= 1'b0;
    end else begin
      sub_prev_q    <= subclock_level;
      watchdog_tick <= 1'b0;
      if (sys_div_q == SYS_W'(WDT_SYS_DIV - 1)) begin
        sys_div_q <= '0;
        if (wdt_src == WDT_SRC_SYS) watchdog_tick <= 1'b1;
      end else begin
        sys_div_q <= sys_div_q + SYS_W'(1);
      end
      if (sub_rise) begin
        if (sub_div_q == SUB_W'(WDT_SUB_DIV - 1)) begin
          sub_div_q <= '0;
          if (wdt_src == WDT_SRC_SUB) watchdog_tick <= 1'b1;
        end else begin
          sub_div_q <= sub_div_q + SUB_W'(1);
        end
      end
    end
  end

  // ==========================================================
  // Read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (paddr)
      `OFS_PORT_DATA:      rd_word[7:0] = port_read;
      `OFS_PORT_DIR:       rd_word[7:0] = 8'hff;       // Write-only, reads all ones
      `OFS_PULLUP:         rd_word[7:0] = pullup_q;
      `OFS_EXT_CLK_MODE:   rd_word[7:0] = ext_clk_q;
      `OFS_PORT_FUNC_MODE: rd_word[7:0] = func_mode_q;
      `OFS_VARIANT:        rd_word[0]   = HAS_RESET_OUT;
      default:             rd_word = 32'h0000_0000;
    endcase
  end

  // Unmapped offsets answer with an error and change nothing
  assign pslverr = psel && penable && !addr_hit;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= rd_word;
    end
  end

endmodule

// *** design/port3_pkg.sv ***
// Purpose: shared types for the port 3 pin function block
// Assumes: nothing beyond the config header
// Notes:   types only
package port3_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic {WDT_SRC_SYS, WDT_SRC_SUB} wdt_src_e;
endpackage

// *** tb/port3_pin_function_select_assertions.sv ***
// Purpose: port-level checks for the port 3 pin function block
// Assumes: zero-wait APB, variant with the reset output
// Notes:   mode bits are mirrored from the APB writes seen
`include "port3_cfg.svh"
module port3_pin_function_select_assertions (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        reset_n,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  // Pins and peripherals
  input wire logic        pwm_in,
  input wire logic        chip_reset_active,
  input wire logic [7:0]  port_pin_out,
  input wire logic [7:0]  port_pin_oe,
  input wire logic        event_count_low_input,
  input wire logic        event_count_high_input,
  input wire logic        up_down_control_input,
  input wire logic        watchdog_clock_select,
  input wire logic        capture_noise_filter_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic [7:0] fm_q;
  logic       ec_q;
  logic       wr;
  assign wr = psel && penable && pwrite && pstrb[0];
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fm_q <= `RST_PORT_FUNC_MODE;
      ec_q <= 1'b0;
    end else if (wr && paddr == `OFS_PORT_FUNC_MODE) begin
      fm_q <= pwdata[7:0];
    end else if (wr && paddr == `OFS_EXT_CLK_MODE) begin
      ec_q <= pwdata[7];
    end
  end
  // ==========
  // Pin effect lags the mode write by one edge
  property p_pwm; $past(fm_q[0]) |-> port_pin_oe[0] && port_pin_out[0] == $past(pwm_in); endproperty
  a_pwm: assert property (p_pwm) else $error("pwm pin wrong");
  property p_rsto; $past(reset_n) && $past(fm_q[2]) |->
    port_pin_oe[2] && port_pin_out[2] == !$past(chip_reset_active); endproperty
  a_rsto: assert property (p_rsto) else $error("reset out pin wrong");
  property p_evl; $past(fm_q[7]) ? !port_pin_oe[7] : !event_count_low_input; endproperty
  a_evl: assert property (p_evl) else $error("pin 7 event wrong");
  property p_evh; $past(fm_q[6]) ? !port_pin_oe[6] : !event_count_high_input; endproperty
  a_evh: assert property (p_evh) else $error("pin 6 event wrong");
  property p_wdt; $stable(fm_q[5]) |-> watchdog_clock_select == fm_q[5]; endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog select wrong");
  property p_ncs; $stable(fm_q[4]) |-> capture_noise_filter_enable == fm_q[4]; endproperty
  a_ncs: assert property (p_ncs) else $error("noise filter wrong");
  property p_ud; !$past(fm_q[1]) |-> !up_down_control_input; endproperty
  a_ud: assert property (p_ud) else $error("up down wrong");
  property p_external_clock_input; $past(ec_q) |-> !port_pin_oe[1] && !up_down_control_input; endproperty
  a_external_clock_input: assert property (p_external_clock_input) else $error("pin 1 clock wrong");
  c_pwm: cover property (fm_q[0] && port_pin_out[0]);
  c_external_clock_input: cover property (ec_q && !port_pin_oe[1]);
  c_evt: cover property (event_count_low_input && event_count_high_input);
endmodule
bind port3_pin_function_select port3_pin_function_select_assertions
  port3_pin_function_select_assertions_inst (
  .ref_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pwm_in,
  .chip_reset_active, .port_pin_out, .port_pin_oe, .event_count_low_input,
  .event_count_high_input, .up_down_control_input, .watchdog_clock_select,
  .capture_noise_filter_enable
);

// *** tb/port3_pin_function_select_test.sv ***
// Purpose: self-checking bench for the port 3 pin function block
// Assumes: zero-wait APB slave, variant with the reset output
// Notes:   watchdog dividers cut to 16 and 4 to keep the run short
`include "port3_cfg.svh"
module port3_pin_function_select_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        pwm_in = 1'b0;
  logic        chip_reset_active = 1'b0;
  logic        neighbour_bit3_in = 1'b0;
  logic [3:0]  pstrb = 4'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [7:0]  ext_drive = 8'h00;
  logic [31:0] prdata;
  logic [7:0]  port_pin_in, port_pin_out, port_pin_oe;
  logic        pready, pslverr, subclock_in, event_count_low_input, event_count_high_input;
  logic        up_down_control_input, external_clock_input, external_clock_enable;
  logic        capture_noise_filter_enable, watchdog_clock_select, watchdog_tick;
  logic        external_interrupt_zero, neighbour_bit3_data;
  logic [7:0]  port_pullup_en;
  int          error_cnt = 0;
  int          compares = 0;
  int          i, n;
  logic [7:0]  f, c, dr, dt, x, o, q, u;
  logic        p, k;
  always #50 ref_clk = ~ref_clk;
  port3_pin_function_select #(.WDT_SYS_DIV(16), .WDT_SUB_DIV(4)) port3_pin_function_select_inst (
    .ref_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .port_pin_in, .port_pin_out, .port_pin_oe, .port_pullup_en,
    .neighbour_bit3_in, .neighbour_bit3_data, .external_interrupt_zero, .pwm_in,
    .chip_reset_active, .subclock_in, .event_count_low_input, .event_count_high_input,
    .up_down_control_input, .external_clock_input, .external_clock_enable,
    .timer_capture_input(), .capture_noise_filter_enable, .watchdog_clock_select, .watchdog_tick);
  port3_pins_model port3_pins_model_inst (.port_pin_out, .port_pin_oe, .external_clock_enable,
    .ext_drive, .port_pin_in, .subclock_in);
  // ==========
  // Expectations
  function automatic logic [7:0] exp_oe(logic [7:0] f, logic [7:0] r, logic e);
    exp_oe = (r & ~(f & 8'hc2)) | (f & 8'h05);
    if (e) exp_oe[1] = 1'b0;
  endfunction
  function automatic logic [7:0] exp_out(logic [7:0] f, logic [7:0] t, logic p, logic k);
    exp_out = t;
    if (f[0]) exp_out[0] = p;
    if (f[2]) exp_out[2] = !k;
  endfunction
  // ==========
  // Bus and checks
  task automatic finish_test;
    $display("Counts: %0d errors, %0d compares", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    int t;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= 4'hf;
    @(posedge ref_clk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge ref_clk);
      t++;
    end while (pready !== 1'b1 && t < 16);
    if (pready !== 1'b1) begin
      chk(32'h0, 32'h1);
      finish_test;
    end else begin
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] m, input logic [31:0] x,
                    input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 8'h00, r, e);
    chk(r & {24'hffffff, m}, x);
    chk(32'(e), 32'(xe));
  endtask
  // ==========
  // Main sequence
  initial begin
    void'($urandom(32'he97ea111));
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(`OFS_PORT_FUNC_MODE, 8'hff, 32'h04, 1'b0);
    rd(`OFS_EXT_CLK_MODE, 8'hff, 32'h58, 1'b0);
    rd(`OFS_PORT_DIR, 8'hff, 32'hff, 1'b0);
    rd(12'h0f0, 8'hff, 32'h0, 1'b1);
    for (i = 0; i < 40; i++) begin
      c = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      {f, dr, dt, x} = $urandom;
      {p, k} = 2'($urandom);
      u = 8'($urandom);
      pwm_in <= p;
      chip_reset_active <= k;
      neighbour_bit3_in <= x[3];
      ext_drive <= x;
      wr(`OFS_EXT_CLK_MODE, c);
      wr(`OFS_PORT_FUNC_MODE, f);
      wr(`OFS_PORT_DIR, dr);
      wr(`OFS_PORT_DATA, dt);
      wr(`OFS_PULLUP, u);
      o = exp_oe(f, dr, c[7]);
      q = exp_out(f, dt, p, k);
      rd(`OFS_EXT_CLK_MODE, 8'hff, 32'((c & 8'ha7) | 8'h58), 1'b0);
      rd(`OFS_PORT_FUNC_MODE, 8'hff, 32'(f), 1'b0);
      rd(`OFS_PORT_DATA, {6'h3f, !c[7], 1'b1},
         32'(((dt & dr) | (((q & o) | (x & ~o)) & ~dr)) & {6'h3f, !c[7], 1'b1}), 1'b0);
      chk(32'(port_pin_oe), 32'(o));
      chk(32'(port_pin_out & o), 32'(q & o));
      chk(32'({event_count_low_input, event_count_high_input}), 32'(f[7:6] & x[7:6]));
      chk(32'(up_down_control_input), 32'(f[1] & !c[7] & x[1]));
      chk(32'({watchdog_clock_select, capture_noise_filter_enable}), 32'(f[5:4]));
      chk(32'({external_interrupt_zero, neighbour_bit3_data}), 32'({f[3], !f[3]} & {2{x[3]}}));
      rd(`OFS_PULLUP, 8'hff, 32'(u), 1'b0);
      chk(32'(port_pullup_en), 32'(u & ~dr & ~((f & 8'hc7) | {6'h00, c[7], 1'b0})));
      n = 0;
      repeat (20) begin
        @(posedge ref_clk);
        if (external_clock_input === 1'b1) n++;
      end
      chk(32'(n > 0 && n < 20), 32'(c[7]));
    end
    for (i = 0; i < 2; i++) begin
      wr(`OFS_PORT_FUNC_MODE, i ? 8'h20 : 8'h00);
      repeat (40) @(posedge ref_clk);
      n = 0;
      repeat (400) begin
        @(posedge ref_clk);
        if (watchdog_tick === 1'b1) n++;
      end
      chk(32'(i ? (n >= 3 && n <= 4) : n == 25), 32'h1);
    end
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(`OFS_PORT_FUNC_MODE, 8'hff, 32'h04, 1'b0);
    rd(`OFS_EXT_CLK_MODE, 8'hff, 32'h58, 1'b0);
    chk(32'(port_pin_oe), 32'h04);
    finish_test;
  end
endmodule

// *** tb/port3_pins_model.sv ***
// Purpose: board model for the port 3 pins
// Assumes: every pin has an outside driver that yields to the block
// Notes:   the board clock stands still unless pin 1 is a clock input
module port3_pins_model (
  // From the block
  input  wire logic [7:0] port_pin_out,
  input  wire logic [7:0] port_pin_oe,
  input  wire logic       external_clock_enable,
  // Board side
  input  wire logic [7:0] ext_drive,
  output logic      [7:0] port_pin_in,
  output logic            subclock_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       board_clk = 1'b0;
  logic [7:0] board;
  initial subclock_in = 1'b0;
  // Unrelated in phase to ref_clk on purpose
  always #1530 subclock_in = ~subclock_in;
  always #170 board_clk = external_clock_enable ? ~board_clk : 1'b0;
  always_comb begin
    board = ext_drive;
    if (external_clock_enable) board[1] = board_clk;
    port_pin_in = (port_pin_oe & port_pin_out) | (~port_pin_oe & board);
  end
endmodule
